// >>> include/dcf_consts.vh
/*
 * constants for the nine-bit pin-driven buffer: register offsets,
 * field positions and reset values.
 * assumes: included by its bare name from the design files under hw/.
 */
`ifndef DCF_CONSTS_VH
`define DCF_CONSTS_VH

// ----------------------------------------------------------------
// register map (byte addresses, one aligned 32-bit word each)
// ----------------------------------------------------------------
`define DCF_PADDR_W 8
`define DCF_REG_CTRL 8'h00
`define DCF_REG_STATUS 8'h04
`define DCF_REG_AE_OFS 8'h08
`define DCF_REG_AF_OFS 8'h0c
`define DCF_REG_LEVEL 8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DCF_CTRL_FLUSH 0
`define DCF_ST_EMPTY_N 0
`define DCF_ST_FULL_N 1
`define DCF_ST_AE_N 2
`define DCF_ST_AF_N 3
`define DCF_ST_TWO_EN 4
`define DCF_ST_OFS_SEL 5

// ----------------------------------------------------------------
// offset reset value, word width and synchroniser depth
// ----------------------------------------------------------------
`define DCF_OFS_DEFAULT 7
`define DCF_WORD_W 9
`define DCF_SYNC_STAGES 2

`endif

// >>> hw/dcf_sync.v
/*
 * two-flop synchroniser for a bundle of pin levels.
 * assumes: each bit is a level from outside the pclk domain.
 */
`timescale 1ns/100ps

module dcf_sync #(
	parameter WIDTH = 17
) (
	input wire clk,
	input wire rst_n,
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);

reg [WIDTH-1:0] meta;

// first stage feeds only the second stage
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		meta <= {WIDTH{1'b0}};
		dout <= {WIDTH{1'b0}};
	end else begin
		meta <= din;
		dout <= meta;
	end
end

endmodule // dcf_sync

// >>> hw/dcf_store.v
/*
 * word store for the buffer: one write port, one combinational read port.
 * assumes: the controller never reads the slot it writes in the same cycle.
 */
`timescale 1ns/100ps

module dcf_store #(
	parameter WIDTH = 9,
	parameter ADDR_W = 10
) (
	input wire clk,
	input wire wr_en,
	input wire [ADDR_W-1:0] wr_addr,
	input wire [WIDTH-1:0] wr_data,
	input wire [ADDR_W-1:0] rd_addr,
	output wire [WIDTH-1:0] rd_data
);

reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

// store one word per write strobe
always @(posedge clk) begin
	if (wr_en) begin
		mem[wr_addr] <= wr_data;
	end
end

assign rd_data = mem[rd_addr];

endmodule // dcf_store

// >>> hw/dcf_fifo_top.v
/*
 * nine-bit first-in first-out buffer driven from pins, with empty, full
 * and programmable almost-empty / almost-full flags, plus an apb window
 * onto its offsets, flags and fill level.
 * assumes: write_clk and read_clk are pin clocks well below pclk / 4;
 * every pin input is asynchronous and passes a two-flop synchroniser.
 */
`timescale 1ns/100ps
`include "dcf_consts.vh"

module dcf_fifo_top #(
	parameter ADDR_W = 10
) (
	input wire pclk,
	input wire presetn,
	input wire [`DCF_PADDR_W-1:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire write_clk,
	input wire read_clk,
	input wire [`DCF_WORD_W-1:0] write_data_in,
	input wire primary_write_enable_n,
	input wire secondary_enable_or_offset_load,
	input wire first_read_enable_n,
	input wire second_read_enable_n,
	input wire output_enable_n,
	input wire buffer_reset_n,
	output reg [`DCF_WORD_W-1:0] read_data_out,
	output reg read_data_oe,
	output reg empty_flag_n,
	output reg full_flag_n,
	output reg prog_almost_empty_flag_n,
	output reg prog_almost_full_flag_n
);

localparam WW = `DCF_WORD_W;
localparam SYNC_W = WW + 8;
localparam [ADDR_W:0] DEPTH_C = {1'b1, {ADDR_W{1'b0}}};
localparam [ADDR_W-1:0] OFS_DEFAULT = `DCF_OFS_DEFAULT;
localparam [ADDR_W:0] ONE_C = {{ADDR_W{1'b0}}, 1'b1};

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
wire [SYNC_W-1:0] pin_raw;
wire [SYNC_W-1:0] pin_s;
wire [WW-1:0] s_data;
wire s_wclk;
wire s_rclk;
wire s_primary_write_enable_n_n;
wire s_dual;
wire s_first_read_enable_n_n;
wire s_second_read_enable_n_n;
wire s_oe_n;
wire s_rst_n;

// data travels with its clock so both arrive aligned
assign pin_raw = {buffer_reset_n, output_enable_n, second_read_enable_n, first_read_enable_n,
	secondary_enable_or_offset_load, primary_write_enable_n, read_clk, write_clk, write_data_in};

dcf_sync #(
	.WIDTH(SYNC_W)
) u_sync (
	.clk(pclk),
	.rst_n(presetn),
	.din(pin_raw),
	.dout(pin_s)
);

assign s_data = pin_s[WW-1:0];
assign s_wclk = pin_s[WW];
assign s_rclk = pin_s[WW+1];
assign s_primary_write_enable_n_n = pin_s[WW+2];
assign s_dual = pin_s[WW+3];
assign s_first_read_enable_n_n = pin_s[WW+4];
assign s_second_read_enable_n_n = pin_s[WW+5];
assign s_oe_n = pin_s[WW+6];
assign s_rst_n = pin_s[WW+7];

// ----------------------------------------------------------------
// pin clock edge detection
// ----------------------------------------------------------------
reg wclk_prev;
reg rclk_prev;
reg [1:0] sync_fill;
wire wr_edge;
wire rd_edge;

// previous level of each synchronised pin clock; sync_fill marks real pin levels
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		wclk_prev <= 1'b0;
		rclk_prev <= 1'b0;
		sync_fill <= 2'b00;
	end else begin
		wclk_prev <= s_wclk;
		rclk_prev <= s_rclk;
		sync_fill <= {sync_fill[0], 1'b1};
	end
end

assign wr_edge = s_wclk & ~wclk_prev;
assign rd_edge = s_rclk & ~rclk_prev;

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg two_enable_mode;
reg ofs_sel;
reg [ADDR_W:0] wr_ptr;
reg [ADDR_W:0] rd_ptr;
reg [ADDR_W-1:0] ae_ofs;
reg [ADDR_W-1:0] af_ofs;

// ----------------------------------------------------------------
// apb decode
// ----------------------------------------------------------------
wire apb_setup;
wire apb_wr;
wire sw_flush;
wire apb_ae_wr;
wire apb_af_wr;

assign apb_setup = psel & ~penable;
assign apb_wr = psel & penable & pready & pwrite;
assign sw_flush = apb_wr & (paddr == `DCF_REG_CTRL) & pwdata[`DCF_CTRL_FLUSH];
assign apb_ae_wr = apb_wr & (paddr == `DCF_REG_AE_OFS);
assign apb_af_wr = apb_wr & (paddr == `DCF_REG_AF_OFS);

// ----------------------------------------------------------------
// pin request decode
// ----------------------------------------------------------------
wire offset_load_select_n;
wire load_active;
wire wr_en_ok;
wire wr_do;
wire ofs_wr;
wire rd_req;
wire rd_do;
wire ofs_rd;

assign offset_load_select_n = s_dual;
assign load_active = ~two_enable_mode & ~offset_load_select_n;
// enable terms per mode
assign wr_en_ok = two_enable_mode ? (~s_primary_write_enable_n_n & s_dual)
	: (~s_primary_write_enable_n_n & offset_load_select_n);
// full flag gates the store; a refused write only re-evaluates full and almost-full
assign wr_do = wr_edge & s_rst_n & wr_en_ok & full_flag_n;
assign ofs_wr = wr_edge & s_rst_n & load_active & ~s_primary_write_enable_n_n;
assign rd_req = rd_edge & s_rst_n & ~s_first_read_enable_n_n & ~s_second_read_enable_n_n;
assign rd_do = rd_req & ~load_active & empty_flag_n;
assign ofs_rd = rd_req & load_active;

// ----------------------------------------------------------------
// pointers and levels
// ----------------------------------------------------------------
wire [ADDR_W:0] next_wr_ptr;
wire [ADDR_W:0] next_rd_ptr;
wire [ADDR_W:0] level;
wire [ADDR_W:0] next_level;
wire [ADDR_W:0] next_free;
wire [WW-1:0] rd_word;
wire [ADDR_W-1:0] ofs_now;

assign next_wr_ptr = wr_do ? wr_ptr + ONE_C : wr_ptr;
assign next_rd_ptr = rd_do ? rd_ptr + ONE_C : rd_ptr;
assign level = wr_ptr - rd_ptr;
assign next_level = next_wr_ptr - next_rd_ptr;
assign next_free = DEPTH_C - next_level;
assign ofs_now = ofs_sel ? af_ofs : ae_ofs;

// word store, nine bits side by side
dcf_store #(
	.WIDTH(WW),
	.ADDR_W(ADDR_W)
) u_store (
	.clk(pclk),
	.wr_en(wr_do),
	.wr_addr(wr_ptr[ADDR_W-1:0]),
	.wr_data(s_data),
	.rd_addr(rd_ptr[ADDR_W-1:0]),
	.rd_data(rd_word)
);

// ----------------------------------------------------------------
// mode, pointers and offset registers
// ----------------------------------------------------------------
// mode follows the dual pin while reset holds, frozen at release
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		two_enable_mode <= 1'b1;
		wr_ptr <= {(ADDR_W+1){1'b0}};
		rd_ptr <= {(ADDR_W+1){1'b0}};
		ofs_sel <= 1'b0;
		ae_ofs <= OFS_DEFAULT;
		af_ofs <= OFS_DEFAULT;
	end else if (!s_rst_n) begin
		// zeros left by the synchroniser reset must not pick load mode
		if (sync_fill[1]) begin
			two_enable_mode <= s_dual;
		end
		wr_ptr <= {(ADDR_W+1){1'b0}};
		rd_ptr <= {(ADDR_W+1){1'b0}};
		ofs_sel <= 1'b0;
		ae_ofs <= OFS_DEFAULT;
		af_ofs <= OFS_DEFAULT;
	end else if (sw_flush) begin
		wr_ptr <= {(ADDR_W+1){1'b0}};
		rd_ptr <= {(ADDR_W+1){1'b0}};
	end else begin
		wr_ptr <= next_wr_ptr;
		rd_ptr <= next_rd_ptr;
		// one step per cycle even if load write and read coincide
		if (ofs_wr | ofs_rd) begin
			ofs_sel <= ~ofs_sel;
		end
		// pin load wins over a software write to the same offset
		if (ofs_wr && !ofs_sel) begin
			ae_ofs <= {{(ADDR_W-WW){1'b0}}, s_data};
		end else if (apb_ae_wr) begin
			ae_ofs <= pwdata[ADDR_W-1:0];
		end
		if (ofs_wr && ofs_sel) begin
			af_ofs <= {{(ADDR_W-WW){1'b0}}, s_data};
		end else if (apb_af_wr) begin
			af_ofs <= pwdata[ADDR_W-1:0];
		end
	end
end

// ----------------------------------------------------------------
// read-side flags and data
// ----------------------------------------------------------------
// empty and almost-empty move only on read clock edges, buffer reset and apb flush
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		empty_flag_n <= 1'b0;
		prog_almost_empty_flag_n <= 1'b0;
		read_data_out <= {WW{1'b0}};
		read_data_oe <= 1'b0;
	end else begin
		read_data_oe <= ~s_oe_n;
		if (!s_rst_n || sw_flush) begin
			empty_flag_n <= 1'b0;
			prog_almost_empty_flag_n <= 1'b0;
			read_data_out <= {WW{1'b0}};
		end else begin
			if (rd_edge) begin
				empty_flag_n <= (next_level != {(ADDR_W+1){1'b0}});
				prog_almost_empty_flag_n <= (next_level > {1'b0, ae_ofs});
			end
			if (ofs_rd) begin
				read_data_out <= ofs_now[WW-1:0];
			end else if (rd_do) begin
				read_data_out <= rd_word;
			end
		end
	end
end

// ----------------------------------------------------------------
// write-side flags
// ----------------------------------------------------------------
// full and almost-full move only on write clock edges, buffer reset and apb flush
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		full_flag_n <= 1'b1;
		prog_almost_full_flag_n <= 1'b1;
	end else if (!s_rst_n || sw_flush) begin
		full_flag_n <= 1'b1;
		prog_almost_full_flag_n <= 1'b1;
	end else if (wr_edge) begin
		full_flag_n <= (next_level != DEPTH_C);
		prog_almost_full_flag_n <= (next_free > {1'b0, af_ofs});
	end
end

// ----------------------------------------------------------------
// apb slave: no wait states, answer registered in the setup cycle
// ----------------------------------------------------------------
reg [31:0] rd_mux;
reg addr_hit;

// read data and decode for the addressed word
always @* begin
	rd_mux = 32'h0000_0000;
	addr_hit = 1'b1;
	case (paddr)
		`DCF_REG_CTRL: begin
			rd_mux = 32'h0000_0000;
		end
		`DCF_REG_STATUS: begin
			rd_mux[`DCF_ST_EMPTY_N] = empty_flag_n;
			rd_mux[`DCF_ST_FULL_N] = full_flag_n;
			rd_mux[`DCF_ST_AE_N] = prog_almost_empty_flag_n;
			rd_mux[`DCF_ST_AF_N] = prog_almost_full_flag_n;
			rd_mux[`DCF_ST_TWO_EN] = two_enable_mode;
			rd_mux[`DCF_ST_OFS_SEL] = ofs_sel;
		end
		`DCF_REG_AE_OFS: begin
			rd_mux[ADDR_W-1:0] = ae_ofs;
		end
		`DCF_REG_AF_OFS: begin
			rd_mux[ADDR_W-1:0] = af_ofs;
		end
		`DCF_REG_LEVEL: begin
			rd_mux[ADDR_W:0] = level;
		end
		default: begin
			addr_hit = 1'b0;
		end
	endcase
end

// pready rises for the access phase only
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h0000_0000;
	end else if (apb_setup) begin
		pready <= 1'b1;
		pslverr <= ~addr_hit;
		prdata <= pwrite ? 32'h0000_0000 : rd_mux;
	end else begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h0000_0000;
	end
end

endmodule // dcf_fifo_top

// >>> bench/dcf_fifo_chk.sv
/*
 * checker for dcf_fifo_top: apb answer timing, flag update domains,
 * buffer reset state and output drive.
 * assumes: bound to dcf_fifo_top; one pclk domain; apb flush used only
 * while the flags already show the empty state.
 */
`timescale 1ns/100ps
`include "dcf_consts.vh"

module dcf_fifo_chk #(
	parameter ADDR_W = 10
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire write_clk,
	input wire read_clk,
	input wire output_enable_n,
	input wire buffer_reset_n,
	input wire [`DCF_WORD_W-1:0] read_data_out,
	input wire read_data_oe,
	input wire empty_flag_n,
	input wire full_flag_n,
	input wire prog_almost_empty_flag_n,
	input wire prog_almost_full_flag_n
);
	reg rd_d;
	reg wr_d;
	reg [3:0] rd_age;
	reg [3:0] wr_age;
	reg [3:0] rs_age;

	// ----------------------------------------------------------------
	// cycles since last pin clock rise or buffer reset, saturating
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_d <= 1'h0;
			wr_d <= 1'h0;
			rd_age <= 4'hf;
			wr_age <= 4'hf;
			rs_age <= 4'h0;
		end else begin
			rd_d <= read_clk;
			wr_d <= write_clk;
			rd_age <= (read_clk && !rd_d) ? 4'h0 : rd_age + (rd_age != 4'hf);
			wr_age <= (write_clk && !wr_d) ? 4'h0 : wr_age + (wr_age != 4'hf);
			rs_age <= !buffer_reset_n ? 4'h0 : rs_age + (rs_age != 4'hf);
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no answer one cycle after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready stood longer than one cycle");
	a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error answer without pready or with data");
	a_oe_drive_on: assert property ((!output_enable_n) [*5] |=> read_data_oe)
		else $error("data pins not driven while enable low");
	a_oe_release: assert property (output_enable_n [*5] |=> !read_data_oe)
		else $error("data pins driven while enable high");
	a_reset_empty_flags: assert property ((!buffer_reset_n) [*5] |=> !empty_flag_n && full_flag_n
		&& !prog_almost_empty_flag_n && prog_almost_full_flag_n)
		else $error("flags not empty state under buffer reset");
	a_reset_data_low: assert property ((!buffer_reset_n) [*5] |=> read_data_out == 9'h000)
		else $error("read data not low under buffer reset");
	a_empty_read_only: assert property ($changed(empty_flag_n) || $changed(prog_almost_empty_flag_n)
		|-> rd_age < 4'h8 || rs_age < 4'h8)
		else $error("empty side flag moved without read clock");
	a_full_write_only: assert property ($changed(full_flag_n) || $changed(prog_almost_full_flag_n)
		|-> wr_age < 4'h8 || rs_age < 4'h8)
		else $error("full side flag moved without write clock");
endmodule // dcf_fifo_chk

bind dcf_fifo_top dcf_fifo_chk #(.ADDR_W(ADDR_W)) i_chk (.pclk, .presetn, .psel, .penable, .prdata,
	.pready, .pslverr, .write_clk, .read_clk, .output_enable_n, .buffer_reset_n, .read_data_out,
	.read_data_oe, .empty_flag_n, .full_flag_n, .prog_almost_empty_flag_n, .prog_almost_full_flag_n);

// >>> bench/dcf_pin_model.sv
/*
 * producer and consumer on the buffer pins: pin clocks, enables, data.
 * assumes: pclk at 125 MHz; pin clocks stand still between transfers.
 */
`timescale 1ns/100ps
`include "dcf_consts.vh"

module dcf_pin_model (
	input wire pclk,
	input wire [`DCF_WORD_W-1:0] read_data_out,
	output logic write_clk,
	output logic read_clk,
	output logic [`DCF_WORD_W-1:0] write_data_in,
	output logic primary_write_enable_n,
	output logic secondary_enable_or_offset_load,
	output logic first_read_enable_n,
	output logic second_read_enable_n
);
	// ----------------------------------------------------------------
	// idle pin levels
	// ----------------------------------------------------------------
	initial begin
		write_clk = 1'h0;
		read_clk = 1'h0;
		write_data_in = 9'h000;
		primary_write_enable_n = 1'h1;
		secondary_enable_or_offset_load = 1'h1;
		first_read_enable_n = 1'h1;
		second_read_enable_n = 1'h1;
	end

	// one write edge; g stretches the high phase for a slow producer
	task wr(input [8:0] d, input logic p, input int g);
		@(posedge pclk);
		write_data_in <= d;
		primary_write_enable_n <= p;
		repeat (3) @(posedge pclk);
		write_clk <= 1'h1;
		repeat (3 + g) @(posedge pclk);
		write_clk <= 1'h0;
		write_data_in <= ~d; // released bus never shows the old word
		primary_write_enable_n <= 1'h1;
		repeat (3) @(posedge pclk);
	endtask

	// one read edge with enables r, then the word on the data pins
	task rd(input [1:0] r, input int g, output [8:0] q);
		@(posedge pclk);
		first_read_enable_n <= r[1];
		second_read_enable_n <= r[0];
		repeat (3) @(posedge pclk);
		read_clk <= 1'h1;
		repeat (3 + g) @(posedge pclk);
		read_clk <= 1'h0;
		first_read_enable_n <= 1'h1;
		second_read_enable_n <= 1'h1;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		q = read_data_out;
	endtask

	// level of the dual pin
	task mode(input logic v);
		@(posedge pclk);
		secondary_enable_or_offset_load <= v;
	endtask
endmodule // dcf_pin_model

// >>> bench/tb.sv
/*
 * testbench for dcf_fifo_top: apb master tasks and pin transfers.
 * assumes: dcf_pin_model drives the transfer pins, tb drives output_enable_n and buffer_reset_n; checker bound to the design.
 */
`timescale 1ns/100ps
`include "dcf_consts.vh"

module tb;
	logic pclk = 1'h0;
	logic presetn, psel, penable, pwrite, output_enable_n, buffer_reset_n, pready, pslverr;
	logic write_clk, read_clk, primary_write_enable_n, secondary_enable_or_offset_load;
	logic first_read_enable_n, second_read_enable_n, read_data_oe, empty_flag_n, full_flag_n;
	logic prog_almost_empty_flag_n, prog_almost_full_flag_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [8:0] write_data_in, read_data_out, q;
	logic [8:0] words [3] = '{9'h1a5, 9'h05a, 9'h100};
	int err_count = 0;
	int samples_checked = 0;
	int i;

	// ----------------------------------------------------------------
	// clock, design and pin partner
	// ----------------------------------------------------------------
	always #4 pclk = ~pclk;

	dcf_fifo_top #(.ADDR_W(10)) i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .write_clk, .read_clk, .write_data_in, .primary_write_enable_n,
		.secondary_enable_or_offset_load, .first_read_enable_n, .second_read_enable_n,
		.output_enable_n, .buffer_reset_n, .read_data_out, .read_data_oe, .empty_flag_n,
		.full_flag_n, .prog_almost_empty_flag_n, .prog_almost_full_flag_n);

	dcf_pin_model i_pins (.pclk, .read_data_out, .write_clk, .read_clk, .write_data_in,
		.primary_write_enable_n, .secondary_enable_or_offset_load, .first_read_enable_n,
		.second_read_enable_n);

	// compare and count
	task chk(input string s, input [31:0] g, input [31:0] x);
		samples_checked++;
		if (g !== x) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", s, x, g);
		end
	endtask

	task results;
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// one apb transfer; read data x and error e expected
	task apb(input string s, input [7:0] a, input logic w, input [31:0] d, input [31:0] x, input logic e);
		int n;
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'h1;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'h1 && n < 16) begin
			@(posedge pclk);
			n++;
		end
		if (pready !== 1'h1) begin
			err_count++;
			results;
		end
		if (!w) chk(s, prdata, x);
		chk("pslverr", pslverr, e);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// buffer reset with dual pin at level v
	task brst(input logic v);
		i_pins.mode(v);
		@(posedge pclk);
		buffer_reset_n <= 1'h0;
		repeat (6) @(posedge pclk);
		buffer_reset_n <= 1'h1;
		repeat (6) @(posedge pclk);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'h0;
		buffer_reset_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		output_enable_n = 1'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		buffer_reset_n <= 1'h1;
		repeat (6) @(posedge pclk);
		chk("read_data_out", read_data_out, 9'h000);
		apb("status", `DCF_REG_STATUS, 1'h0, 32'h0, 32'h0000_001a, 1'h0);
		apb("ae_ofs", `DCF_REG_AE_OFS, 1'h0, 32'h0, 32'h0000_0007, 1'h0);
		apb("af_ofs", `DCF_REG_AF_OFS, 1'h0, 32'h0, 32'h0000_0007, 1'h0);
		apb("unmapped", 8'h14, 1'h0, 32'h0, 32'h0000_0000, 1'h1);
		$display("test defaults done");

		i_pins.wr(9'h1a5, 1'h0, 0);
		i_pins.wr(9'h05a, 1'h0, 2);
		i_pins.mode(1'h0);
		i_pins.wr(9'h0ff, 1'h0, 0);
		i_pins.mode(1'h1);
		i_pins.wr(9'h0ff, 1'h1, 0);
		i_pins.wr(9'h100, 1'h0, 0);
		chk("empty", empty_flag_n, 1'h0);
		apb("level", `DCF_REG_LEVEL, 1'h0, 32'h0, 32'h0000_0003, 1'h0);
		i_pins.rd(2'h1, 0, q);
		i_pins.rd(2'h2, 0, q);
		chk("empty", empty_flag_n, 1'h1);
		apb("level", `DCF_REG_LEVEL, 1'h0, 32'h0, 32'h0000_0003, 1'h0);
		for (i = 0; i < 3; i++) begin
			i_pins.rd(2'h0, i, q);
			chk("word", q, words[i]);
		end
		chk("empty", empty_flag_n, 1'h0);
		chk("almost_empty", prog_almost_empty_flag_n, 1'h0);
		i_pins.rd(2'h0, 0, q);
		chk("held", q, 9'h100);
		$display("test order done");

		for (i = 0; i < 1024; i++) begin
			i_pins.wr(i[8:0], 1'h0, 0);
			if (i == 1015 || i == 1016) chk("almost_full", prog_almost_full_flag_n, i == 1015);
			if (i >= 1022) chk("full", full_flag_n, i == 1022);
		end
		i_pins.wr(9'h1ff, 1'h0, 0);
		apb("level", `DCF_REG_LEVEL, 1'h0, 32'h0, 32'h0000_0400, 1'h0);
		i_pins.rd(2'h2, 0, q);
		chk("almost_empty", prog_almost_empty_flag_n, 1'h1);
		i_pins.rd(2'h0, 0, q);
		chk("first", q, 9'h000);
		chk("full", full_flag_n, 1'h0);
		brst(1'h1);
		chk("flags", {empty_flag_n, full_flag_n, prog_almost_empty_flag_n, prog_almost_full_flag_n}, 4'h5);
		apb("level", `DCF_REG_LEVEL, 1'h0, 32'h0, 32'h0000_0000, 1'h0);
		$display("test full done");

		brst(1'h0);
		apb("ae_ofs", `DCF_REG_AE_OFS, 1'h1, 32'h0000_0123, 32'h0, 1'h0);
		apb("ae_ofs", `DCF_REG_AE_OFS, 1'h0, 32'h0, 32'h0000_0123, 1'h0);
		apb("status", `DCF_REG_STATUS, 1'h1, 32'hffff_ffff, 32'h0, 1'h0);
		apb("status", `DCF_REG_STATUS, 1'h0, 32'h0, 32'h0000_000a, 1'h0);
		i_pins.wr(9'h003, 1'h0, 0);
		i_pins.wr(9'h005, 1'h0, 0);
		apb("ae_ofs", `DCF_REG_AE_OFS, 1'h0, 32'h0, 32'h0000_0003, 1'h0);
		apb("af_ofs", `DCF_REG_AF_OFS, 1'h0, 32'h0, 32'h0000_0005, 1'h0);
		for (i = 0; i < 3; i++) begin
			i_pins.rd(2'h0, 0, q);
			chk("offset", q, (i == 1) ? 9'h005 : 9'h003);
		end
		apb("level", `DCF_REG_LEVEL, 1'h0, 32'h0, 32'h0000_0000, 1'h0);
		i_pins.mode(1'h1);
		i_pins.wr(9'h0aa, 1'h0, 0);
		apb("level", `DCF_REG_LEVEL, 1'h0, 32'h0, 32'h0000_0001, 1'h0);
		apb("status", `DCF_REG_STATUS, 1'h0, 32'h0, 32'h0000_002a, 1'h0);
		apb("ctrl", `DCF_REG_CTRL, 1'h1, 32'h0000_0001, 32'h0, 1'h0);
		apb("ctrl", `DCF_REG_CTRL, 1'h0, 32'h0, 32'h0000_0000, 1'h0);
		apb("level", `DCF_REG_LEVEL, 1'h0, 32'h0, 32'h0000_0000, 1'h0);
		$display("test offsets done");

		output_enable_n <= 1'h1;
		repeat (6) @(negedge pclk);
		chk("oe", read_data_oe, 1'h0);
		@(posedge pclk);
		output_enable_n <= 1'h0;
		repeat (6) @(negedge pclk);
		chk("oe", read_data_oe, 1'h1);
		$display("test drive done");
		results;
	end
endmodule // tb
